// File: design/sfs_pkg.sv
`default_nettype none
package sfs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS     = 20;
  localparam int TW_NS      = 1000000;
  localparam int TW_CYCLES  = (TW_NS + CLK_NS - 1) / CLK_NS;
  localparam int TSHSL2_NS  = 50;
  localparam int VOL_RAW    = TSHSL2_NS / CLK_NS;
  localparam int VOL_CYCLES = (VOL_RAW < 1) ? 1 : VOL_RAW;
  localparam int BUSY_W     = 17;

  ////////////////////////////////////////////////////////////////////////////
  // Command opcodes
  localparam logic [7:0] OP_WREN     = 8'h06;
  localparam logic [7:0] OP_WRDI     = 8'h04;
  localparam logic [7:0] OP_VWREN    = 8'h50;
  localparam logic [7:0] OP_STATUS_ONE_WRITE_CMD    = 8'h01;
  localparam logic [7:0] OP_STATUS_TWO_WRITE_CMD    = 8'h31;
  localparam logic [7:0] OP_RDSR1    = 8'h05;
  localparam logic [7:0] OP_RDSR2    = 8'h35;
  localparam logic [7:0] OP_RDSR3    = 8'h15;
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_FREAD    = 8'h0B;
  localparam logic [7:0] OP_DREAD    = 8'h3B;
  localparam logic [7:0] OP_SETPARAM = 8'hC0;

  ////////////////////////////////////////////////////////////////////////////
  // Status fields and reset values
  localparam int         SR2_STATUS_PROTECT_SECOND    = 3;
  localparam int         SR2_QE      = 4;
  localparam int         SR2_LB      = 5;
  localparam logic [7:0] SR1_WMASK   = 8'hFC;
  localparam logic [7:0] SR2_WMASK   = 8'hFF;
  localparam logic [7:0] SR2_OTP     = 8'h20;
  localparam logic [7:0] SR2_VOL_OTP = 8'h28;
  localparam logic [7:0] SR2_QE_MASK = 8'h10;
  localparam logic [7:0] SR_RESET    = 8'h00;
  localparam logic [7:0] SR3_VALUE   = 8'h00;
  localparam logic [1:0] PARAM_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Frame geometry in serial clocks; synchroniser reset pattern
  localparam logic [3:0] SPI_DUMMY    = 4'h8;
  localparam logic [4:0] SPI_BYTE_CLK = 5'h08;
  localparam logic [4:0] QPI_BYTE_CLK = 5'h02;
  localparam logic [4:0] SPI_ADDR_CLK = 5'h18;
  localparam logic [4:0] QPI_ADDR_CLK = 5'h06;
  localparam logic [5:0] SYNC_RESET   = 6'h20;

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_STAT, ST_WDATA, ST_PARAM, ST_IGNORE
  } sfs_state_t;

  typedef struct packed {
    logic       csN;
    logic       sck;
    logic [3:0] dq;
  } sfs_pin_in_t;

  typedef struct packed {
    logic [3:0] dq;
    logic [3:0] oe;
  } sfs_pin_out_t;

endpackage : sfs_pkg
`default_nettype wire

// File: design/sfs_fifo.sv
`default_nettype none
module sfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and control
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             clear,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [PW-1:0]    next_wrPtr;
  logic [PW-1:0]    next_rdPtr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign inReady  = (count != CW'(DEPTH)) && !clear;
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady && !clear;

  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (clear) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
    end else begin
      if (push) begin
        next_wrPtr = (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
      end
      if (pop) begin
        next_rdPtr = (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
      end
      next_count = count + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (ce) begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      if (push) begin
        mem[wrPtr] <= inData;
      end
    end
  end

endmodule : sfs_fifo
`default_nettype wire

// File: design/sfs_flash_cmd.sv
`default_nettype none
module sfs_flash_cmd
  import sfs_pkg::*;
#(
  parameter int WRITE_CYCLES = TW_CYCLES
) (
  // Clock, reset, enable
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Serial link pins
  input  wire sfs_pin_in_t  pinIn,
  output var  sfs_pin_out_t pinOut,
  // Mode and reset controls
  input  wire logic         fourWireMode,
  input  wire logic         softReset,
  // Status view
  output logic [7:0]        statusOne,
  output logic [7:0]        statusTwo,
  output logic              writeInProgress,
  output logic              writeEnableLatch,
  // Array byte stream
  output logic              arrReq,
  output logic [23:0]       arrAddr,
  input  wire logic         arrValid,
  input  wire logic [7:0]   arrData
);

  typedef struct packed {
    sfs_state_t            state;
    logic                  sckPrev;
    logic                  csPrev;
    logic [4:0]            bitCnt;
    logic [23:0]           shIn;
    logic [7:0]            cmd;
    logic [3:0]            dummyN;
    logic [2:0]            outW;
    logic [3:0]            outCnt;
    logic [7:0]            shOut;
    logic [1:0]            statSel;
    logic [1:0]            byteCnt;
    logic [7:0]            wd1;
    logic [7:0]            wd2;
    logic [7:0]            sr1;
    logic [7:0]            sr2;
    logic [7:0]            nv1;
    logic [7:0]            nv2;
    logic                  write_enable_latch;
    logic                  volEn;
    logic                  busy;
    logic [BUSY_W-1:0]     busyCnt;
    logic                  volPend;
    logic [3:0]            volCnt;
    logic [1:0]            pendWr;
    logic [7:0]            pend1;
    logic [7:0]            pend2;
    logic [1:0]            readParam;
    logic [23:0]           fetchAddr;
    sfs_pin_out_t          pins;
  } sfs_ctl_t;

  localparam sfs_ctl_t CTL_RESET = '{state: ST_CMD, csPrev: 1'h1, sr1: SR_RESET,
                                     sr2: SR_RESET, nv1: SR_RESET, nv2: SR_RESET,
                                     readParam: PARAM_RESET, default: '0};
  localparam int VOL_WAIT = VOL_CYCLES + 1;

  sfs_ctl_t    st;
  sfs_ctl_t    next_st;
  logic [5:0]  pinVec;
  logic [5:0]  syncOut;
  logic        csS;
  logic        sckS;
  logic [3:0]  dqS;
  logic        cmdDone;
  logic [7:0]  cmdByte;
  logic        fifoPop;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [7:0]  fifoOutData;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [23:0] shiftIn(input logic [23:0] sh, input logic [3:0] dq,
                                          input logic four_wire_command_mode);
    shiftIn = four_wire_command_mode ? {sh[19:0], dq} : {sh[22:0], dq[0]};
  endfunction : shiftIn

  function automatic logic [7:0] mergeStatus(input logic [7:0] old, input logic [7:0] data,
                                             input logic [7:0] mask, input logic [7:0] keep);
    mergeStatus = (old & ~mask) | (data & mask) | (old & keep);
  endfunction : mergeStatus

  function automatic logic [3:0] outClocks(input logic [2:0] w);
    case (w)
      3'h4:    outClocks = 4'h2;
      3'h2:    outClocks = 4'h4;
      default: outClocks = 4'h8;
    endcase
  endfunction : outClocks

  function automatic logic [3:0] lineDrive(input logic [7:0] b, input logic [2:0] w);
    case (w)
      3'h4:    lineDrive = b[7:4];
      3'h2:    lineDrive = {2'h0, b[7:6]};
      default: lineDrive = {2'h0, b[7], 1'h0};
    endcase
  endfunction : lineDrive

  function automatic logic [3:0] lineMask(input logic [2:0] w);
    case (w)
      3'h4:    lineMask = 4'hF;
      3'h2:    lineMask = 4'h3;
      default: lineMask = 4'h2;
    endcase
  endfunction : lineMask

  function automatic logic [7:0] shiftOut(input logic [7:0] b, input logic [2:0] w);
    case (w)
      3'h4:    shiftOut = {b[3:0], 4'h0};
      3'h2:    shiftOut = {b[5:0], 2'h0};
      default: shiftOut = {b[6:0], 1'h0};
    endcase
  endfunction : shiftOut

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  assign pinVec = pinIn;

  genvar gi;
  for (gi = 0; gi < 6; gi++) begin : g_sync
    logic stageA;
    logic stageB;
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        stageA <= SYNC_RESET[gi];
        stageB <= SYNC_RESET[gi];
      end else if (ce) begin
        stageA <= pinVec[gi];
        stageB <= stageA;
      end
    end
    assign syncOut[gi] = stageB;
  end

  assign csS  = syncOut[5];
  assign sckS = syncOut[4];
  assign dqS  = syncOut[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Read prefetch buffer; it stalls the array stream when full
  assign arrReq = (st.state == ST_DATA) && !csS && fifoInReady;

  sfs_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .ce       (ce),
    .clear    (csS),
    .inValid  (arrReq && arrValid),
    .inReady  (fifoInReady),
    .inData   (arrData),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command interpreter and status store
  always_comb begin
    logic [23:0] shNext;
    logic [7:0]  outByte;
    logic [4:0]  byteClk;
    logic [4:0]  cntNext;
    logic        wr2;
    logic [7:0]  d2;
    logic [7:0]  qeKeep;
    shNext  = shiftIn(st.shIn, dqS, fourWireMode);
    outByte = st.shOut;
    byteClk = fourWireMode ? QPI_BYTE_CLK : SPI_BYTE_CLK;
    cntNext = st.bitCnt + 5'h01;
    wr2     = (st.cmd == OP_STATUS_TWO_WRITE_CMD) || (st.byteCnt == 2'h2);
    d2      = (st.cmd == OP_STATUS_TWO_WRITE_CMD) ? st.wd1 : st.wd2;
    qeKeep  = fourWireMode ? SR2_QE_MASK : 8'h00;
    next_st = st;
    cmdDone = 1'h0;
    cmdByte = shNext[7:0];
    fifoPop = 1'h0;
    next_st.sckPrev = sckS;
    next_st.csPrev  = csS;

    if (st.busy) begin
      if (st.busyCnt == BUSY_W'(1)) begin
        next_st.busy = 1'h0;
        next_st.write_enable_latch  = 1'h0;
        if (st.pendWr[0]) begin
          next_st.nv1 = st.pend1;
          next_st.sr1 = st.pend1;
        end
        if (st.pendWr[1]) begin
          next_st.nv2 = st.pend2;
          next_st.sr2 = st.pend2;
        end
      end else begin
        next_st.busyCnt = st.busyCnt - BUSY_W'(1);
      end
    end

    if (st.volPend) begin
      if (st.volCnt == 4'h1) begin
        next_st.volPend = 1'h0;
        if (st.pendWr[0]) begin
          next_st.sr1 = st.pend1;
        end
        if (st.pendWr[1]) begin
          next_st.sr2 = st.pend2;
        end
      end else begin
        next_st.volCnt = st.volCnt - 4'h1;
      end
    end

    if (arrReq && arrValid) begin
      next_st.fetchAddr = st.fetchAddr + 24'h00_0001;
    end

    if (csS) begin
      // Commit happens on the rise of select, only after a whole data byte
      if (!st.csPrev && st.state == ST_WDATA && st.byteCnt != 2'h0) begin
        next_st.pendWr = {wr2, st.cmd == OP_STATUS_ONE_WRITE_CMD};
        if (st.volEn) begin
          next_st.pend1   = mergeStatus(st.sr1, st.wd1, SR1_WMASK, 8'h00);
          next_st.pend2   = mergeStatus(st.sr2, d2, SR2_WMASK, SR2_VOL_OTP | qeKeep);
          next_st.volPend = 1'h1;
          next_st.volCnt  = 4'(VOL_CYCLES);
          next_st.volEn   = 1'h0;
        end else if (st.write_enable_latch) begin
          next_st.pend1   = mergeStatus(st.nv1, st.wd1, SR1_WMASK, 8'h00);
          next_st.pend2   = mergeStatus(st.nv2, d2, SR2_WMASK, SR2_OTP | qeKeep)
                            | (st.sr2 & qeKeep);
          next_st.busy    = 1'h1;
          next_st.busyCnt = BUSY_W'(WRITE_CYCLES);
        end
      end
      next_st.state   = ST_CMD;
      next_st.bitCnt  = 5'h00;
      next_st.outCnt  = 4'h0;
      next_st.byteCnt = 2'h0;
      next_st.pins.oe = 4'h0;
    end else if (sckS && !st.sckPrev) begin
      next_st.shIn   = shNext;
      next_st.bitCnt = cntNext;
      case (st.state)
        ST_CMD: begin
          if (cntNext == byteClk) begin
            cmdDone        = 1'h1;
            next_st.cmd    = cmdByte;
            next_st.bitCnt = 5'h00;
            next_st.state  = ST_IGNORE;
            next_st.outW   = fourWireMode ? 3'h4 : 3'h1;
            case (cmdByte)
              OP_WREN: begin
                if (!st.busy) begin
                  next_st.write_enable_latch = 1'h1;
                end
              end
              OP_WRDI: begin
                if (!st.busy) begin
                  next_st.write_enable_latch = 1'h0;
                end
              end
              OP_VWREN: begin
                if (!st.busy) begin
                  next_st.volEn = 1'h1;
                end
              end
              OP_STATUS_ONE_WRITE_CMD, OP_STATUS_TWO_WRITE_CMD: begin
                if (!st.busy) begin
                  next_st.state = ST_WDATA;
                end
              end
              OP_RDSR1, OP_RDSR2, OP_RDSR3: begin
                next_st.state   = ST_STAT;
                next_st.statSel = (cmdByte == OP_RDSR1) ? 2'h0 :
                                  (cmdByte == OP_RDSR2) ? 2'h1 : 2'h2;
              end
              OP_READ: begin
                if (!st.busy && !fourWireMode) begin
                  next_st.state  = ST_ADDR;
                  next_st.dummyN = 4'h0;
                end
              end
              OP_FREAD: begin
                if (!st.busy) begin
                  next_st.state  = ST_ADDR;
                  next_st.dummyN = fourWireMode ? {1'h0, st.readParam, 1'h0} + 4'h2
                                                : SPI_DUMMY;
                end
              end
              OP_DREAD: begin
                if (!st.busy && !fourWireMode) begin
                  next_st.state  = ST_ADDR;
                  next_st.dummyN = SPI_DUMMY;
                  next_st.outW   = 3'h2;
                end
              end
              OP_SETPARAM: begin
                if (!st.busy) begin
                  next_st.state = ST_PARAM;
                end
              end
              default: next_st.state = ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          if (cntNext == (fourWireMode ? QPI_ADDR_CLK : SPI_ADDR_CLK)) begin
            next_st.fetchAddr = shNext;
            next_st.bitCnt    = 5'h00;
            next_st.state     = (st.dummyN == 4'h0) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // Input lines are don't care here
          if (cntNext == {1'h0, st.dummyN}) begin
            next_st.bitCnt = 5'h00;
            next_st.state  = ST_DATA;
          end
        end
        ST_WDATA: begin
          if (cntNext == byteClk) begin
            next_st.bitCnt = 5'h00;
            if (st.byteCnt == 2'h0) begin
              next_st.wd1 = cmdByte;
            end else if (st.byteCnt == 2'h1) begin
              next_st.wd2 = cmdByte;
            end
            if (st.byteCnt != 2'h2) begin
              next_st.byteCnt = st.byteCnt + 2'h1;
            end
          end
        end
        ST_PARAM: begin
          if (cntNext == byteClk) begin
            next_st.readParam = cmdByte[5:4];
            next_st.state     = ST_IGNORE;
          end
        end
        default: next_st.state = st.state;
      endcase
    end else if (!sckS && st.sckPrev && (st.state == ST_DATA || st.state == ST_STAT)) begin
      if (st.outCnt == 4'h0) begin
        if (st.state == ST_DATA) begin
          outByte = fifoOutData;
          fifoPop = 1'h1;
        end else begin
          case (st.statSel)
            2'h0:    outByte = {st.sr1[7:2], st.write_enable_latch, st.busy};
            2'h1:    outByte = st.sr2;
            default: outByte = SR3_VALUE;
          endcase
        end
        next_st.outCnt = outClocks(st.outW) - 4'h1;
      end else begin
        next_st.outCnt = st.outCnt - 4'h1;
      end
      // Line zero is driven only at dual and four-wire width; single width drives line one only
      next_st.pins.dq = lineDrive(outByte, st.outW);
      next_st.pins.oe = lineMask(st.outW);
      next_st.shOut   = shiftOut(outByte, st.outW);
    end

    if (softReset) begin
      next_st.sr1       = st.nv1;
      next_st.sr2       = st.nv2;
      next_st.volEn     = 1'h0;
      next_st.volPend   = 1'h0;
      next_st.readParam = PARAM_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= CTL_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign pinOut           = st.pins;
  assign statusOne        = {st.sr1[7:2], st.write_enable_latch, st.busy};
  assign statusTwo        = st.sr2;
  assign writeInProgress  = st.busy;
  assign writeEnableLatch = st.write_enable_latch;
  assign arrAddr          = st.fetchAddr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_otp_lock_kept: assert property (
    st.nv2[SR2_LB] |=> st.nv2[SR2_LB]) else $error("lock bit cleared");
  chk_nv_needs_wel: assert property (
    $rose(st.busy) |-> $past(st.write_enable_latch)) else $error("write cycle without latch");
  chk_busy_holds: assert property (
    $rose(st.busy) |-> st.busy [*8]) else $error("write cycle too short");
  chk_wel_cleared: assert property (
    $fell(st.busy) |-> !st.write_enable_latch) else $error("latch kept after write cycle");
  chk_vol_quiet: assert property (
    $rose(st.volPend) |-> !st.busy throughout ##[1:VOL_WAIT] !st.volPend)
    else $error("volatile update late or busy");
  chk_vol_no_wel: assert property (
    st.volPend && !st.write_enable_latch |=> !st.write_enable_latch) else $error("latch set by volatile write");
  chk_qe_kept_qpi: assert property (
    fourWireMode && st.sr2[SR2_QE] && !softReset |=> st.sr2[SR2_QE])
    else $error("quad enable cleared in four-wire mode");
  chk_soft_reload: assert property (
    softReset && !st.busy |=> st.sr2 == $past(st.nv2) && st.readParam == PARAM_RESET)
    else $error("software reset did not reload");
  chk_read_refused: assert property (
    cmdDone && cmdByte == OP_READ && (st.busy || fourWireMode) |=> st.state == ST_IGNORE)
    else $error("normal read accepted while refused");
  chk_qpi_dummy: assert property (
    cmdDone && fourWireMode && cmdByte == OP_FREAD && !st.busy
    |=> st.dummyN == {1'h0, $past(st.readParam), 1'h0} + 4'h2) else $error("dummy count wrong");
  chk_spi_dummy: assert property (
    cmdDone && !fourWireMode && cmdByte == OP_DREAD && !st.busy
    |=> st.dummyN == SPI_DUMMY && st.outW == 3'h2) else $error("dual read setup wrong");
  chk_addr_step: assert property (
    arrReq && arrValid |=> st.fetchAddr == $past(st.fetchAddr) + 24'h00_0001)
    else $error("read address did not advance");

  cov_nv_write:   cover property ($rose(st.busy));
  cov_vol_write:  cover property ($fell(st.volPend));
  cov_poll_busy:  cover property (st.state == ST_STAT && st.busy && !sckS && st.sckPrev);
  cov_dual_byte:  cover property (fifoPop && st.outW == 3'h2);

endmodule : sfs_flash_cmd
`default_nettype wire

// File: tb/sfs_array_model.sv
`default_nettype none
module sfs_array_model (
  // Clock and control
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  // Byte stream
  input  wire logic        arrReq,
  input  wire logic [23:0] arrAddr,
  output logic             arrValid,
  output logic [7:0]       arrData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tick;
  always_ff @(posedge sys_clk) begin
    tick <= rst ? 1'b0 : ~tick;
  end
  // Slow mode answers every other cycle so the buffer sees a stalling source
  assign arrValid = arrReq && (!slow || tick);
  // No stale byte between transfers: the bus shows the inverse pattern
  assign arrData  = arrValid ? (arrAddr[7:0] ^ 8'ha5) : ~(arrAddr[7:0] ^ 8'ha5);
endmodule : sfs_array_model
`default_nettype wire

// File: tb/tb_serial_flash_status_write_and_read.sv
`default_nettype none
module tb_serial_flash_status_write_and_read import sfs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic         sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, slow = 1'b0;
  logic         fourWireMode = 1'b0, softReset = 1'b0;
  sfs_pin_in_t  pinIn = '{csN: 1'b1, sck: 1'b0, dq: 4'h0};
  sfs_pin_out_t pinOut;
  logic [7:0]   statusOne, statusTwo, arrData, b;
  logic         writeInProgress, writeEnableLatch, arrReq, arrValid;
  logic [23:0]  arrAddr;
  logic [3:0]   q;
  int           badCount = 0, comparisons = 0;

  always #10 sys_clk = ~sys_clk;

  sfs_flash_cmd #(.WRITE_CYCLES(800)) dut_u (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .pinIn(pinIn), .pinOut(pinOut), .fourWireMode(fourWireMode), .softReset(softReset),
    .statusOne(statusOne), .statusTwo(statusTwo), .writeInProgress(writeInProgress),
    .writeEnableLatch(writeEnableLatch), .arrReq(arrReq), .arrAddr(arrAddr),
    .arrValid(arrValid), .arrData(arrData));
  sfs_array_model src_u (.sys_clk(sys_clk), .rst(rst), .slow(slow), .arrReq(arrReq),
    .arrAddr(arrAddr), .arrValid(arrValid), .arrData(arrData));

  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // One link clock of 160 ns; output sampled late in the high phase, where it stands
  task automatic xfer(input logic [3:0] d);
    pinIn.sck <= 1'b0;
    pinIn.dq  <= d;
    tick(4);
    pinIn.sck <= 1'b1;
    tick(4);
    q = pinOut.dq;
  endtask : xfer
  // Four-wire mode moves a nibble per link clock, high nibble first
  task automatic sbyte(input logic [7:0] v);
    if (fourWireMode) begin
      xfer(v[7:4]);
      xfer(v[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) xfer({3'h0, v[i]});
    end
  endtask : sbyte
  task automatic getb(input bit dual);
    for (int j = 0; j < (fourWireMode ? 2 : dual ? 4 : 8); j++) begin
      xfer(4'h0);
      b = fourWireMode ? {b[3:0], q} : dual ? {b[5:0], q[1:0]} : {b[6:0], q[1]};
    end
  endtask : getb
  task automatic cs_low;
    pinIn.csN <= 1'b0;
    tick(4);
  endtask : cs_low
  task automatic cs_up;
    pinIn.sck <= 1'b0;
    tick(4);
    pinIn.csN <= 1'b1;
    tick(6);
  endtask : cs_up
  task automatic cmd(input logic [7:0] op, input logic [15:0] d, input int n);
    cs_low();
    sbyte(op);
    for (int i = 0; i < n; i++) sbyte(d[15-8*i -: 8]);
    cs_up();
  endtask : cmd
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_idle;
    for (int i = 0; i < 2000 && writeInProgress !== 1'b0; i++) tick(1);
  endtask : wait_idle
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int dum, input bit dual);
    cs_low();
    sbyte(op);
    for (int i = 2; i >= 0; i--) sbyte(a[8*i +: 8]);
    repeat (dum) xfer(4'h0);
    for (int k = 0; k < 3; k++) begin
      getb(dual);
      check(b, 8'(a + 24'(k)) ^ 8'ha5);
    end
    cs_up();
    $display("Test read %h done", op);
  endtask : rd
  task automatic endOfTest;
    $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : endOfTest

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(30000);
    badCount++;
    endOfTest();
  end

  initial begin
    tick(4);
    rst <= 1'b0;
    tick(4);
    check(statusOne, 8'h00);
    check(statusTwo, 8'h00);
    cmd(OP_WREN, 16'h0000, 0);
    check({7'h0, writeEnableLatch}, 8'h01);
    cmd(OP_STATUS_ONE_WRITE_CMD, 16'hff20, 2);
    check({7'h0, writeInProgress}, 8'h01);
    cs_low();
    sbyte(OP_RDSR1);
    repeat (2) begin
      getb(1'b0);
      check(b, 8'h03);
    end
    cs_up();
    // Array read during the write cycle must not drive the pins
    cs_low();
    sbyte(OP_READ);
    repeat (40) xfer(4'h0);
    check({4'h0, pinOut.oe}, 8'h00);
    cs_up();
    wait_idle();
    check(statusOne, 8'hfc);
    check(statusTwo, 8'h20);
    cmd(OP_STATUS_ONE_WRITE_CMD, 16'h0000, 1);
    check(statusOne, 8'hfc);
    cmd(OP_WREN, 16'h0000, 0);
    cmd(OP_STATUS_TWO_WRITE_CMD, 16'h0000, 1);
    wait_idle();
    check(statusTwo, 8'h20);
    $display("Test non-volatile write done");
    cmd(OP_VWREN, 16'h0000, 0);
    cmd(OP_STATUS_ONE_WRITE_CMD, 16'h0000, 2);
    check(statusOne, 8'h00);
    check(statusTwo, 8'h20);
    softReset <= 1'b1;
    tick(1);
    softReset <= 1'b0;
    tick(3);
    check(statusOne, 8'hfc);
    check(statusTwo, 8'h20);
    $display("Test volatile write done");
    rd(OP_READ, 24'h00_00fe, 0, 1'b0);
    slow <= 1'b1;
    rd(OP_FREAD, 24'h12_34ff, 8, 1'b0);
    slow <= 1'b0;
    rd(OP_DREAD, 24'h00_0080, 8, 1'b1);
    fourWireMode <= 1'b1;
    cs_low();
    xfer(4'h0);
    xfer(4'h3);
    repeat (10) xfer(4'h0);
    check({4'h0, pinOut.oe}, 8'h00);
    cs_up();
    rd(OP_FREAD, 24'h00_0040, 2, 1'b0);
    cmd(OP_SETPARAM, 16'h3000, 1);
    rd(OP_FREAD, 24'h00_0200, 8, 1'b0);
    cmd(OP_VWREN, 16'h0000, 0);
    cmd(OP_STATUS_TWO_WRITE_CMD, 16'h1000, 1);
    check(statusTwo, 8'h30);
    cmd(OP_VWREN, 16'h0000, 0);
    cmd(OP_STATUS_ONE_WRITE_CMD, 16'h0000, 1);
    check(statusOne, 8'h00);
    check(statusTwo, 8'h30);
    cmd(OP_VWREN, 16'h0000, 0);
    cmd(OP_STATUS_TWO_WRITE_CMD, 16'h0000, 1);
    check(statusTwo, 8'h30);
    fourWireMode <= 1'b0;
    $display("Test four-wire mode done");
    endOfTest();
  end
endmodule : tb_serial_flash_status_write_and_read
`default_nettype wire
